// [rtcat_pkg.sv]
// Shared constants and types for the alarm and time-value block.
package rtcat_pkg;

  // ******************************************************************
  // Register offsets on the plain register port.
  // ******************************************************************
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_PAD  = 4'h1;
  localparam logic [3:0] ADR_ACFG = 4'h2;
  localparam logic [3:0] ADR_ALARM_REPEAT_COUNTER = 4'h3;
  localparam logic [3:0] ADR_AWH  = 4'h4;
  localparam logic [3:0] ADR_AWL  = 4'h5;
  localparam logic [3:0] ADR_TWH  = 4'h6;
  localparam logic [3:0] ADR_TWL  = 4'h7;
  localparam logic [3:0] ADR_STAT = 4'h8;

  // ******************************************************************
  // Field positions.
  // ******************************************************************
  localparam int CTRL_UNLOCK_BIT = 5;
  localparam int CTRL_HALF_BIT   = 3;
  localparam int CTRL_OE_BIT     = 2;
  localparam int CTRL_PTR_LSB    = 0;
  localparam int PAD_SRC_LSB     = 1;
  localparam int ACFG_ON_BIT     = 7;
  localparam int ACFG_CHIME_BIT  = 6;
  localparam int ACFG_MASK_LSB   = 2;
  localparam int ACFG_PTR_LSB    = 0;
  localparam int STAT_FLAG_BIT   = 0;

  // ******************************************************************
  // Encodings and reset values.
  // ******************************************************************
  localparam logic [1:0] SRC_ALARM  = 2'h0;
  localparam logic [1:0] SRC_SECCLK = 2'h1;
  localparam logic [3:0] MASK_HALF    = 4'h0;
  localparam logic [3:0] MASK_SEC     = 4'h1;
  localparam logic [3:0] MASK_TENSEC  = 4'h2;
  localparam logic [3:0] MASK_MIN     = 4'h3;
  localparam logic [3:0] MASK_TENMIN  = 4'h4;
  localparam logic [3:0] MASK_HOUR    = 4'h5;
  localparam logic [3:0] MASK_DAY     = 4'h6;
  localparam logic [3:0] MASK_WEEK    = 4'h7;
  localparam logic [3:0] MASK_MONTH   = 4'h8;
  localparam logic [3:0] MASK_YEAR    = 4'h9;
  localparam logic [7:0] RPT_MAX      = 8'hFF;
  localparam logic [7:0] CFG_RESET    = 8'h00;

  // Time fields, in the order that the value arrays use.
  typedef enum logic [2:0] {
    FLD_SEC, FLD_MIN, FLD_HOUR, FLD_WEEKDAY_DIGIT, FLD_DAY, FLD_MONTH, FLD_YEAR, FLD_NONE
  } rtcat_field_t;

  // Implemented bits of each field, second first.
  localparam logic [6:0][7:0] FIELD_MASK = {8'hFF, 8'h1F, 8'h3F, 8'h07, 8'h3F, 8'h7F, 8'h7F};
  // Midnight, 1 January of year 00, a Sunday.
  localparam logic [6:0][7:0] TIME_RESET = {8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] SEC_MAX   = 8'h59;
  localparam logic [7:0] MIN_MAX   = 8'h59;
  localparam logic [7:0] HOUR_MAX  = 8'h23;
  localparam logic [7:0] WEEKDAY_DIGIT_MAX  = 8'h06;
  localparam logic [7:0] MONTH_MAX = 8'h12;
  localparam logic [7:0] YEAR_MAX  = 8'h99;

  // ******************************************************************
  // Timing.
  // ******************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int HALF_SEC_NS   = 500000000;
  localparam int HALF_SEC_CYC  = HALF_SEC_NS / CLK_PERIOD_NS;

endpackage

// [rtcat_tick.sv]
// Half-second and one-second time base derived from the system clock.
`timescale 1ns/10ps
module rtcat_tick
  import rtcat_pkg::*;
#(
  parameter int HALF_CYC = HALF_SEC_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic clear,
  output logic      half_tick,
  output logic      sec_tick,
  output logic      half_flag
);

  typedef struct packed {
    logic [25:0] cnt;
    logic        half;
    logic        ht;
    logic        st;
  } rtcat_tick_t;

  rtcat_tick_t s_r, s_nxt;

  // Counts half periods; a write to the seconds restarts the second.
  always_comb begin
    s_nxt = s_r;
    s_nxt.ht = 1'b0;
    s_nxt.st = 1'b0;
    if (clear) begin
      s_nxt.cnt  = '0;
      s_nxt.half = 1'b0;
    end else if (s_r.cnt == 26'(HALF_CYC - 1)) begin
      s_nxt.cnt  = '0;
      s_nxt.half = ~s_r.half;
      s_nxt.ht   = 1'b1;
      s_nxt.st   = s_r.half;
    end else begin
      s_nxt.cnt = s_r.cnt + 26'h0000001;
    end
  end

  // Registers the time base state.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign half_tick = s_r.ht;
  assign sec_tick  = s_r.st;
  assign half_flag = s_r.half;

endmodule // rtcat_tick

// [rtcat_clock.sv]
// BCD time and calendar counters with a field write port.
`timescale 1ns/10ps
module rtcat_clock
  import rtcat_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             sec_tick,
  input  wire logic             wr_en,
  input  rtcat_field_t          wr_field,
  input  wire logic [7:0]       wr_data,
  output logic      [6:0][7:0]  time_val
);

  typedef struct packed {
    logic [6:0][7:0] f;
  } rtcat_clock_t;

  rtcat_clock_t s_r, s_nxt;
  logic [8:0]   c_sec, c_min, c_hour, c_weekday_digit, c_day, c_month, c_year;

  // Steps one BCD field; bit 8 flags the wrap back to the lowest value.
  function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] vmax,
                                          input logic [7:0] vmin);
    if (v >= vmax) begin
      return {1'b1, vmin};
    end else if (v[3:0] == 4'h9) begin
      return {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      return {1'b0, v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // Last day of a month in BCD, with February grown in years divisible by four.
  function automatic logic [7:0] month_len(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) :
                  (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    if (m == 8'h02) begin
      return leap ? 8'h29 : 8'h28;
    end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
      return 8'h30;
    end else begin
      return 8'h31;
    end
  endfunction

  // Candidate next value of each field.
  assign c_sec   = bcd_step(s_r.f[FLD_SEC], SEC_MAX, 8'h00);
  assign c_min   = bcd_step(s_r.f[FLD_MIN], MIN_MAX, 8'h00);
  assign c_hour  = bcd_step(s_r.f[FLD_HOUR], HOUR_MAX, 8'h00);
  assign c_weekday_digit  = bcd_step(s_r.f[FLD_WEEKDAY_DIGIT], WEEKDAY_DIGIT_MAX, 8'h00);
  assign c_day   = bcd_step(s_r.f[FLD_DAY], month_len(s_r.f[FLD_MONTH], s_r.f[FLD_YEAR]), 8'h01);
  assign c_month = bcd_step(s_r.f[FLD_MONTH], MONTH_MAX, 8'h01);
  assign c_year  = bcd_step(s_r.f[FLD_YEAR], YEAR_MAX, 8'h00);

  // Ripples carries on each second; a software write wins for its own field.
  always_comb begin
    s_nxt = s_r;
    if (sec_tick) begin
      s_nxt.f[FLD_SEC] = c_sec[7:0];
      if (c_sec[8]) begin
        s_nxt.f[FLD_MIN] = c_min[7:0];
        if (c_min[8]) begin
          s_nxt.f[FLD_HOUR] = c_hour[7:0];
          if (c_hour[8]) begin
            s_nxt.f[FLD_WEEKDAY_DIGIT] = c_weekday_digit[7:0];
            s_nxt.f[FLD_DAY]  = c_day[7:0];
            if (c_day[8]) begin
              s_nxt.f[FLD_MONTH] = c_month[7:0];
              if (c_month[8]) begin
                s_nxt.f[FLD_YEAR] = c_year[7:0];
              end
            end
          end
        end
      end
    end
    if (wr_en && wr_field != FLD_NONE) begin
      s_nxt.f[wr_field] = wr_data & FIELD_MASK[wr_field];
    end
  end

  // Registers the calendar.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r.f <= TIME_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign time_val = s_r.f;

endmodule // rtcat_clock

// [rtcat_top.sv]
// Alarm, output pin select and windowed time-value registers of the clock unit.
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
// What this block does
// - Source select 01 routes the seconds clock to the pin, 00 the alarm pulse.
// - The pin is driven only while the clock output enable bit is set.
// - Alarm on clears itself after an event when counter is zero and not chiming.
// - The eight-bit repeat counter counts down once per alarm event.
// - At zero the counter holds, or wraps to FF in repeat-forever mode.
// - Mask codes 0 to 5: half second, second, ten seconds, minute, ten minutes, hour.
// - Mask codes 6 to 9: daily, weekly, monthly, yearly; 29 February fires leap years.
// - Alarm pointer selects minute, weekday, month high; second, hour, day low.
// - Alarm pointer counts down on each high-window access, stopping at 00.
// - Year holds two BCD digits in bits 7-4 and 3-0.
// - Month tens in bit 4, ones in bits 3-0, bits 7-5 read zero.
// - Day tens in bits 5-4, ones in bits 3-0.
// - Weekday 0 to 6 in bits 2-0, upper bits read zero.
// - Hour tens in bits 5-4, ones in bits 3-0, 24-hour form.
// - Minute tens in bits 6-4, ones in bits 3-0, bit 7 reads zero.
// - Second tens in bits 6-4, ones in bits 3-0, bit 7 reads zero.
// - Year to hour writes land only while the write unlock bit is set.
// - Unused bits and the reserved slot read zero and ignore writes.
// - Time pointer selects minute, weekday, month, reserved high; second to year low.
// - Time window writes are ignored while the write unlock bit is clear.
module rtcat_top
  import rtcat_pkg::*;
#(
  parameter int HALF_SEC_CYC_P = HALF_SEC_CYC
) (
  input  wire logic       CLK,
  input  wire logic       RSTN,
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  output logic            RTC_OUT,
  output logic            RTC_OUT_EN,
  output logic            ALARM_EVENT
);

  // ******************************************************************
  // State.
  // ******************************************************************
  typedef struct packed {
    logic            unlock;
    logic            oe;
    logic [1:0]      tptr;
    logic [1:0]      srcsel;
    logic            on;
    logic            chime;
    logic [3:0]      mask;
    logic [1:0]      aptr;
    logic [7:0]      rpt;
    logic [5:0][7:0] aval;
    logic            flag;
    logic            pulse;
    logic            pin;
    logic [7:0]      rdata;
    logic            half_d;
    logic            sec_d;
  } rtcat_top_t;

  rtcat_top_t      st_r, st_nxt;
  logic            half_tick, sec_tick, half_flag, tick_clear;
  logic [6:0][7:0] time_val;
  logic            tw_en;
  rtcat_field_t    tw_field;
  rtcat_field_t    afld, tfld;
  logic            win_access, fire;

  // ******************************************************************
  // Decoding helpers.
  // ******************************************************************

  // Maps a window pointer to the field it reaches; the alarm side has no year.
  function automatic rtcat_field_t win_field(input logic high, input logic [1:0] ptr,
                                             input logic alarm);
    case ({high, ptr})
      3'b100:  return FLD_MIN;
      3'b101:  return FLD_WEEKDAY_DIGIT;
      3'b110:  return FLD_MONTH;
      3'b000:  return FLD_SEC;
      3'b001:  return FLD_HOUR;
      3'b010:  return FLD_DAY;
      3'b011:  return alarm ? FLD_NONE : FLD_YEAR;
      default: return FLD_NONE;
    endcase
  endfunction

  // Compares the fields that the interval mask keeps against the alarm values.
  function automatic logic fields_match(input logic [3:0] m, input logic [6:0][7:0] t,
                                        input logic [5:0][7:0] a);
    logic s_eq, m_eq, h_eq, d_eq;
    s_eq = (t[FLD_SEC] == a[FLD_SEC]);
    m_eq = s_eq && (t[FLD_MIN] == a[FLD_MIN]);
    h_eq = m_eq && (t[FLD_HOUR] == a[FLD_HOUR]);
    d_eq = h_eq && (t[FLD_DAY] == a[FLD_DAY]);
    case (m)
      MASK_SEC:    return 1'b1;
      MASK_TENSEC: return t[FLD_SEC][3:0] == a[FLD_SEC][3:0];
      MASK_MIN:    return s_eq;
      MASK_TENMIN: return s_eq && (t[FLD_MIN][3:0] == a[FLD_MIN][3:0]);
      MASK_HOUR:   return m_eq;
      MASK_DAY:    return h_eq;
      MASK_WEEK:   return h_eq && (t[FLD_WEEKDAY_DIGIT] == a[FLD_WEEKDAY_DIGIT]);
      MASK_MONTH:  return d_eq;
      MASK_YEAR:   return d_eq && (t[FLD_MONTH] == a[FLD_MONTH]);
      default:     return 1'b0;
    endcase
  endfunction

  // ******************************************************************
  // Time base and calendar.
  // ******************************************************************
  rtcat_tick #(
    .HALF_CYC (HALF_SEC_CYC_P)
  ) u_tick (
    .clk       (CLK),
    .rst_n     (RSTN),
    .clear     (tick_clear),
    .half_tick (half_tick),
    .sec_tick  (sec_tick),
    .half_flag (half_flag)
  );

  rtcat_clock u_clock (
    .clk      (CLK),
    .rst_n    (RSTN),
    .sec_tick (sec_tick),
    .wr_en    (tw_en),
    .wr_field (tw_field),
    .wr_data  (WDATA),
    .time_val (time_val)
  );

  // ******************************************************************
  // Alarm detection.
  // ******************************************************************

  // Matches are judged one cycle after a tick, once the calendar has moved.
  assign fire = st_r.on &&
                ((st_r.mask == MASK_HALF && st_r.half_d) ||
                 (st_r.sec_d && fields_match(st_r.mask, time_val, st_r.aval)));

  // Window targets and the shared access strobe of all four windows, high and low.
  assign afld       = win_field(ADDR == ADR_AWH, st_r.aptr, 1'b1);
  assign tfld       = win_field(ADDR == ADR_TWH, st_r.tptr, 1'b0);
  assign win_access = (WR || RD) && (ADDR == ADR_AWH || ADDR == ADR_AWL ||
                                     ADDR == ADR_TWH || ADDR == ADR_TWL);

  // ******************************************************************
  // Next-state logic.
  // ******************************************************************

  // Alarm event effects first, then register writes, then read data.
  always_comb begin
    st_nxt        = st_r;
    tw_en         = 1'b0;
    tw_field      = FLD_NONE;
    tick_clear    = 1'b0;
    st_nxt.half_d = half_tick;
    st_nxt.sec_d  = sec_tick;
    st_nxt.pulse  = fire;

    // Sticky flag: a write of one clears it, a same-cycle event keeps it set.
    if (WR && ADDR == ADR_STAT && WDATA[STAT_FLAG_BIT]) begin
      st_nxt.flag = 1'b0;
    end
    if (fire) begin
      st_nxt.flag = 1'b1;
      if (st_r.rpt != 8'h00) begin
        st_nxt.rpt = st_r.rpt - 8'h01;
      end else if (st_r.chime) begin
        st_nxt.rpt = RPT_MAX;
      end
      if (st_r.rpt == 8'h00 && !st_r.chime) begin
        st_nxt.on = 1'b0;
      end
    end

    // Register writes; a write beats an alarm event in the same cycle.
    if (WR) begin
      if (ADDR == ADR_CTRL) begin
        st_nxt.unlock = WDATA[CTRL_UNLOCK_BIT];
        st_nxt.oe     = WDATA[CTRL_OE_BIT];
        st_nxt.tptr   = WDATA[CTRL_PTR_LSB +: 2];
      end else if (ADDR == ADR_PAD) begin
        st_nxt.srcsel = WDATA[PAD_SRC_LSB +: 2];
      end else if (ADDR == ADR_ACFG) begin
        st_nxt.on    = WDATA[ACFG_ON_BIT];
        st_nxt.chime = WDATA[ACFG_CHIME_BIT];
        st_nxt.mask  = WDATA[ACFG_MASK_LSB +: 4];
        st_nxt.aptr  = WDATA[ACFG_PTR_LSB +: 2];
      end else if (ADDR == ADR_ALARM_REPEAT_COUNTER) begin
        st_nxt.rpt = WDATA;
      end else if (ADDR == ADR_AWH || ADDR == ADR_AWL) begin
        if (afld != FLD_NONE) begin
          st_nxt.aval[afld] = WDATA & FIELD_MASK[afld];
        end
      end else if (ADDR == ADR_TWH || ADDR == ADR_TWL) begin
        if (st_r.unlock && tfld != FLD_NONE) begin
          tw_en      = 1'b1;
          tw_field   = tfld;
          tick_clear = (tfld == FLD_SEC);
        end
      end
    end

    // High-window accesses step the pointers down, stopping at zero.
    if (win_access && ADDR == ADR_AWH && st_r.aptr != 2'h0) begin
      st_nxt.aptr = st_r.aptr - 2'h1;
    end
    if (win_access && ADDR == ADR_TWH && st_r.tptr != 2'h0) begin
      st_nxt.tptr = st_r.tptr - 2'h1;
    end

    // Read data stands for one cycle only; unmapped reads return zero.
    st_nxt.rdata = 8'h00;
    if (RD) begin
      if (ADDR == ADR_CTRL) begin
        st_nxt.rdata[CTRL_UNLOCK_BIT]     = st_r.unlock;
        st_nxt.rdata[CTRL_HALF_BIT]       = half_flag;
        st_nxt.rdata[CTRL_OE_BIT]         = st_r.oe;
        st_nxt.rdata[CTRL_PTR_LSB +: 2]   = st_r.tptr;
      end else if (ADDR == ADR_PAD) begin
        st_nxt.rdata[PAD_SRC_LSB +: 2]    = st_r.srcsel;
      end else if (ADDR == ADR_ACFG) begin
        st_nxt.rdata[ACFG_ON_BIT]         = st_r.on;
        st_nxt.rdata[ACFG_CHIME_BIT]      = st_r.chime;
        st_nxt.rdata[ACFG_MASK_LSB +: 4]  = st_r.mask;
        st_nxt.rdata[ACFG_PTR_LSB +: 2]   = st_r.aptr;
      end else if (ADDR == ADR_ALARM_REPEAT_COUNTER) begin
        st_nxt.rdata = st_r.rpt;
      end else if (ADDR == ADR_AWH || ADDR == ADR_AWL) begin
        if (afld != FLD_NONE) begin
          st_nxt.rdata = st_r.aval[afld];
        end
      end else if (ADDR == ADR_TWH || ADDR == ADR_TWL) begin
        if (tfld != FLD_NONE) begin
          st_nxt.rdata = time_val[tfld];
        end
      end else if (ADDR == ADR_STAT) begin
        st_nxt.rdata[STAT_FLAG_BIT] = st_r.flag;
      end
    end

    // Output pin: chosen source, gated by the output enable.
    if (!st_r.oe) begin
      st_nxt.pin = 1'b0;
    end else if (st_r.srcsel == SRC_SECCLK) begin
      st_nxt.pin = half_flag;
    end else if (st_r.srcsel == SRC_ALARM) begin
      st_nxt.pin = fire;
    end else begin
      st_nxt.pin = 1'b0;
    end
  end

  // ******************************************************************
  // State register.
  // ******************************************************************

  // Synchronous reset puts all control and alarm state to zero.
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign RDATA       = st_r.rdata;
  assign RTC_OUT     = st_r.pin;
  assign RTC_OUT_EN  = st_r.oe;
  assign ALARM_EVENT = st_r.pulse;

  // ******************************************************************
  // Assertions.
  // ******************************************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  property p_pin_off;
    !st_r.oe |=> !RTC_OUT;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin driven while disabled");

  property p_sec_clock;
    st_r.oe && st_r.srcsel == SRC_SECCLK |=> RTC_OUT == $past(half_flag);
  endproperty
  a_sec_clock: assert property (p_sec_clock) else $error("seconds clock not on pin");

  property p_auto_off;
    fire && st_r.rpt == 8'h00 && !st_r.chime && !(WR && ADDR == ADR_ACFG) |=> !st_r.on;
  endproperty
  a_auto_off: assert property (p_auto_off) else $error("alarm not disabled");

  property p_rpt_dec;
    fire && st_r.rpt != 8'h00 && !(WR && ADDR == ADR_ALARM_REPEAT_COUNTER)
      |=> st_r.rpt == 8'($past(st_r.rpt) - 8'h01);
  endproperty
  a_rpt_dec: assert property (p_rpt_dec) else $error("repeat count not decremented");

  property p_rpt_wrap;
    fire && st_r.rpt == 8'h00 && !(WR && ADDR == ADR_ALARM_REPEAT_COUNTER)
      |=> st_r.rpt == ($past(st_r.chime) ? RPT_MAX : 8'h00);
  endproperty
  a_rpt_wrap: assert property (p_rpt_wrap) else $error("repeat count wrap wrong");

  property p_aptr_dec;
    (WR || RD) && ADDR == ADR_AWH && st_r.aptr != 2'h0
      |=> st_r.aptr == 2'($past(st_r.aptr) - 2'h1);
  endproperty
  a_aptr_dec: assert property (p_aptr_dec) else $error("alarm pointer not stepped");

  property p_locked;
    WR && (ADDR == ADR_TWL || ADDR == ADR_TWH) && !st_r.unlock && !sec_tick
      |=> time_val == $past(time_val);
  endproperty
  a_locked: assert property (p_locked) else $error("locked time write landed");

  property p_event;
    fire |=> ALARM_EVENT && st_r.flag ##1 !ALARM_EVENT || $past(fire, 1);
  endproperty
  a_event: assert property (p_event) else $error("alarm event not signalled");

  property p_reserved;
    RD && ADDR == ADR_TWH && st_r.tptr == 2'h3 |=> RDATA == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved slot not zero");

endmodule // rtcat_top

// [rtcat_top_tb.sv]
// Self-checking bench for the alarm and time-value block.
`timescale 1ns/10ps
module rtcat_top_tb;
  import rtcat_pkg::*;
  // ********
  // Signals and the unit under test.
  // ********
  localparam int HC = 4;
  logic       CLK;
  logic       RSTN;
  logic [3:0] ADDR;
  logic [7:0] WDATA;
  logic       WR;
  logic       RD;
  logic [7:0] RDATA;
  logic       RTC_OUT;
  logic       RTC_OUT_EN;
  logic       ALARM_EVENT;
  int         failures;
  int         samples_checked;
  int         seed;
  int         n;
  int         c;
  int         q;
  logic [7:0] v [2][4];
  logic [7:0] got;
  // Half seconds between events for interval codes 0 to 5.
  int         gap [6] = '{1, 2, 20, 120, 1200, 7200};

  rtcat_top #(.HALF_SEC_CYC_P(HC)) i_rtcat_top (
    .CLK        (CLK),
    .RSTN       (RSTN),
    .ADDR       (ADDR),
    .WDATA      (WDATA),
    .WR         (WR),
    .RD         (RD),
    .RDATA      (RDATA),
    .RTC_OUT    (RTC_OUT),
    .RTC_OUT_EN (RTC_OUT_EN),
    .ALARM_EVENT(ALARM_EVENT)
  );

  // ********
  // Helpers.
  // ********
  // Free-running clock of 10 ns.
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // Implemented bits of a window byte; alarm code 11 reaches nothing.
  function automatic logic [7:0] fmask(input bit hi, input bit al, input int p);
    logic [7:0] lo_m [4];
    logic [7:0] hi_m [4];
    lo_m = '{8'h7F, 8'h3F, 8'h3F, al ? 8'h00 : 8'hFF};
    hi_m = '{8'h7F, 8'h07, 8'h1F, 8'h00};
    return hi ? hi_m[p] : lo_m[p];
  endfunction

  // Compares and counts; a mismatch is reported at once.
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // One write cycle; the strobe stays up for a following write.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    RD <= 1'b0;
    @(posedge CLK);
  endtask

  // One read cycle; data are taken in the cycle after the strobe.
  task automatic rd(input logic [3:0] a);
    ADDR <= a;
    RD <= 1'b1;
    WR <= 1'b0;
    @(posedge CLK);
    RD <= 1'b0;
    @(posedge CLK);
    got = RDATA;
  endtask

  // Drops both strobes and lets cycles pass.
  task automatic idle(input int k);
    WR <= 1'b0;
    RD <= 1'b0;
    repeat (k) @(posedge CLK);
  endtask

  // Counts cycles up to the next alarm pulse, bounded.
  task automatic wev;
    c = 0;
    do begin
      @(posedge CLK);
      c++;
    end while (ALARM_EVENT !== 1'b1 && c < 40000);
  endtask

  // Prints the verdict and ends the run.
  task automatic stop_test;
    if (failures == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    repeat (95000) @(posedge CLK);
    failures++;
    stop_test();
  end

  // ********
  // Scenarios.
  // ********
  initial begin
    seed = 32'hA5BD;
    failures = 0;
    samples_checked = 0;
    RSTN = 1'b0;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 4'h0;
    WDATA = 8'h00;
    repeat (3) @(posedge CLK);
    RSTN <= 1'b1;
    @(posedge CLK);
    rd(ADR_ACFG);
    chk(got, 8'h00);
    rd(ADR_ALARM_REPEAT_COUNTER);
    chk(got, 8'h00);
    rd(4'hF);
    chk(got, 8'h00);
    // Time windows first, then alarm windows, with random bytes.
    for (int w = 0; w < 2; w++) begin
      for (int p = 0; p < 4; p++) v[w][p] = $random(seed);
      wr(w ? ADR_ACFG : ADR_CTRL, w ? 8'h03 : 8'h23);
      for (int p = 0; p < 4; p++) wr(w ? ADR_AWH : ADR_TWH, v[w][p]);
      wr(w ? ADR_ACFG : ADR_CTRL, w ? 8'h03 : 8'h23);
      for (int p = 3; p >= -1; p--) begin
        q = (p < 0) ? 0 : p;
        rd(w ? ADR_AWH : ADR_TWH);
        chk(got, v[w][3-q] & fmask(1, w, q));
      end
      rd(w ? ADR_ACFG : ADR_CTRL);
      chk(got[1:0], 2'h0);
      for (int p = 3; p >= 0; p--) begin
        wr(w ? ADR_ACFG : ADR_CTRL, (w ? 8'h00 : 8'h20) | 8'(p));
        wr(w ? ADR_AWL : ADR_TWL, v[w][p] ^ 8'hA5);
        rd(w ? ADR_AWL : ADR_TWL);
        chk(got, (v[w][p] ^ 8'hA5) & fmask(0, w, p));
      end
    end
    // Locked writes are dropped, yet the high pointer still steps.
    wr(ADR_CTRL, 8'h03);
    wr(ADR_TWL, 8'h42);
    wr(ADR_TWH, 8'h00);
    rd(ADR_CTRL);
    chk(got & 8'h23, 8'h02);
    wr(ADR_CTRL, 8'h03);
    rd(ADR_TWL);
    chk(got, v[0][3] ^ 8'hA5);
    // Seconds and minutes at zero on both sides, alarm pulse on the pin.
    wr(ADR_CTRL, 8'h24);
    wr(ADR_TWL, 8'h00);
    wr(ADR_TWH, 8'h00);
    wr(ADR_ACFG, 8'h00);
    wr(ADR_AWL, 8'h00);
    wr(ADR_AWH, 8'h00);
    wr(ADR_PAD, 8'h00);
    wr(ADR_ALARM_REPEAT_COUNTER, 8'h02);
    wr(ADR_ACFG, 8'h84);
    idle(0);
    n = 0;
    repeat (48) begin
      @(posedge CLK);
      if (ALARM_EVENT === 1'b1) begin
        n++;
        chk(RTC_OUT, 1'b1);
      end
    end
    chk(n, 3);
    rd(ADR_ACFG);
    chk(got, 8'h04);
    rd(ADR_ALARM_REPEAT_COUNTER);
    chk(got, 8'h00);
    rd(ADR_STAT);
    chk(got[0], 1'b1);
    wr(ADR_STAT, 8'h01);
    rd(ADR_STAT);
    chk(got[0], 1'b0);
    // Repeat-forever wraps the counter and keeps the alarm on.
    wr(ADR_ALARM_REPEAT_COUNTER, 8'h00);
    wr(ADR_ACFG, 8'hC4);
    idle(0);
    wev();
    rd(ADR_ALARM_REPEAT_COUNTER);
    chk(got, 8'hFF);
    rd(ADR_ACFG);
    chk(got, 8'hC4);
    // Spacing of events for interval codes 0 to 5.
    for (int m = 0; m < 6; m++) begin
      wr(ADR_ACFG, 8'hC0 | 8'(m << 2));
      idle(0);
      wev();
      wev();
      chk(c, gap[m] * HC);
    end
    // Daily code: the roll to 13:00:00 fires only when the alarm hour is 13.
    for (int k = 0; k < 2; k++) begin
      wr(ADR_CTRL, 8'h25);
      wr(ADR_TWL, 8'h12);
      wr(ADR_CTRL, 8'h24);
      wr(ADR_TWH, 8'h59);
      wr(ADR_TWL, 8'h58);
      wr(ADR_ACFG, 8'h19);
      wr(ADR_AWL, 8'(8'h12 + k));
      wr(ADR_ACFG, 8'h98);
      idle(0);
      n = 0;
      repeat (24) begin
        @(posedge CLK);
        n += (ALARM_EVENT === 1'b1);
      end
      chk(n, k);
    end
    // Seconds clock on the pin, then the pin disabled.
    wr(ADR_PAD, 8'h02);
    idle(2);
    n = 0;
    repeat (16) begin
      @(posedge CLK);
      n += (RTC_OUT === 1'b1);
    end
    chk(n, 8);
    chk(RTC_OUT_EN, 1'b1);
    wr(ADR_CTRL, 8'h20);
    idle(2);
    repeat (16) begin
      @(posedge CLK);
      n += (RTC_OUT !== 1'b0);
    end
    chk(n, 8);
    chk(RTC_OUT_EN, 1'b0);
    stop_test();
  end
endmodule // rtcat_top_tb
